/* core/scar_regs.vh */
// Register numbers, field positions and reset values of the control and attribute bank
`ifndef SCAR_REGS_VH
`define SCAR_REGS_VH
`define SCAR_RN_CONTROL      4'h1
`define SCAR_RN_CACHABLE     4'h2
`define SCAR_RN_BUFFERABLE   4'h3
`define SCAR_RN_RESERVED     4'h4
`define SCAR_OP2_DATA        3'h0
`define SCAR_OP2_INSTR       3'h1
`define SCAR_BIT_ASYNC       31
`define SCAR_BIT_NFAST       30
`define SCAR_BIT_VECTOR      13
`define SCAR_BIT_INSTRUCTION_CACHE      12
`define SCAR_BIT_BIGEND      7
`define SCAR_BIT_DATA_CACHE      2
`define SCAR_BIT_PROT        0
`define SCAR_VEC_LOW         32'h00000000
`define SCAR_VEC_HIGH        32'hffff0000
`define SCAR_RSVD_ONES       32'h00000078
`define SCAR_RST_BIT         1'h0
`define SCAR_RST_ATTR        8'h00
`define SCAR_MODE_FAST       2'h0
`define SCAR_MODE_SYNC       2'h1
`define SCAR_MODE_RSVD       2'h2
`define SCAR_MODE_ASYNC      2'h3
`endif

/* core/scar_area_attr.v */
// Per-area write treatment decode from cachable and bufferable bits
`default_nettype none
module scar_area_attr (
  input  wire [7:0] cachable,
  input  wire [7:0] bufferable,
  output wire [7:0] wr_buffered,
  output wire [7:0] wr_through
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_area
      // Buffered when marked bufferable; a cached area not bufferable writes through
      assign wr_buffered[g] = bufferable[g];
      assign wr_through[g]  = cachable[g] & ~bufferable[g];
    end
  endgenerate
endmodule // scar_area_attr
`default_nettype wire

/* core/scar_bank.v */
// Control word and memory attribute register bank of the system control coprocessor
// Behaviour
// - Bit 13 picks low or high vectors
// - Bit 12 enables the instruction cache
// - Bit 7 selects big-endian, resets zero
// - Bit 2 enables the data cache
// - Bit 0 enables the protection unit
// - Reserved control bits read back fixed, bits 6:3 as ones
// - Bits 31:30 select the clocking mode
// - Opcode_2 picks data or instruction cachable copy
// - Eight cachable bits, one per area
// - Eight bufferable bits, one per data area
// - Bufferable alone decides write buffering; cachable without bufferable writes through
// - Reset clears all, vector bit loads pin
// - Unprivileged or other coprocessor instructions trap
`include "scar_regs.vh"
`default_nettype none
module scar_bank (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        vector_high_init_pin,
  input  wire        cop_valid,
  input  wire        core_to_coproc_write,
  input  wire        coproc_to_core_read,
  input  wire        other_coproc_instr,
  input  wire        privileged,
  input  wire [3:0]  coproc_reg_number,
  input  wire [2:0]  opcode_2,
  input  wire [31:0] wr_data,
  output reg  [31:0] rd_data_ff,
  output wire        undef_trap,
  output wire [31:0] vector_base,
  output wire        instruction_cache_en,
  output wire        data_cache_en,
  output wire        big_endian,
  output wire        protection_en,
  output wire        async_clock_select,
  output wire        fast_bus_not_select,
  output wire        shared_clock_mode,
  output wire        sync_clock_mode,
  output wire        async_clock_mode,
  output wire        clock_mode_reserved,
  output wire [7:0]  data_cachable,
  output wire [7:0]  instr_cachable,
  output wire [7:0]  area_bufferable_flag,
  output wire [7:0]  data_wr_buffered,
  output wire [7:0]  data_wr_through
);
  reg        async_ff;
  reg        nfast_ff;
  reg        vector_ff;
  reg        instruction_cache_ff;
  reg        bigend_ff;
  reg        data_cache_ff;
  reg        prot_ff;
  reg  [7:0] dcach_ff;
  reg  [7:0] icach_ff;
  reg  [7:0] buf_ff;
  reg  [31:0] nxt_rd_data;

  // Register select decode shared by read and write paths
  function sel;
    input [3:0] rn;
    input [2:0] op2;
    input [3:0] want_rn;
    input [2:0] want_op2;
    begin
      sel = (rn == want_rn) && (op2 == want_op2);
    end
  endfunction

  wire xfer_ok  = cop_valid & privileged & (core_to_coproc_write | coproc_to_core_read);
  wire wr_ok    = xfer_ok & core_to_coproc_write;
  wire rd_ok    = xfer_ok & coproc_to_core_read;
  wire sel_ctl  = (coproc_reg_number == `SCAR_RN_CONTROL);
  wire sel_dc   = sel(coproc_reg_number, opcode_2, `SCAR_RN_CACHABLE, `SCAR_OP2_DATA);
  wire sel_ic   = sel(coproc_reg_number, opcode_2, `SCAR_RN_CACHABLE, `SCAR_OP2_INSTR);
  // Any opcode_2 reaches the single bufferable copy; zero is the software's job
  wire sel_buf  = (coproc_reg_number == `SCAR_RN_BUFFERABLE);

  // Privilege is judged per transfer; data-processing and load/store forms always trap
  assign undef_trap = cop_valid & ((~privileged & (core_to_coproc_write | coproc_to_core_read))
                      | other_coproc_instr);

  // Strap is caught by a clocked reset, so it is safe against a moving pin
  always @(posedge sys_clk) begin
    if (reset) begin
      async_ff  <= `SCAR_RST_BIT;
      nfast_ff  <= `SCAR_RST_BIT;
      vector_ff <= vector_high_init_pin;
      instruction_cache_ff <= `SCAR_RST_BIT;
      bigend_ff <= `SCAR_RST_BIT;
      data_cache_ff <= `SCAR_RST_BIT;
      prot_ff   <= `SCAR_RST_BIT;
      dcach_ff  <= `SCAR_RST_ATTR;
      icach_ff  <= `SCAR_RST_ATTR;
      buf_ff    <= `SCAR_RST_ATTR;
    end else if (wr_ok) begin
      // Reserved control bits are not stored at all
      if (sel_ctl) begin
        async_ff  <= wr_data[`SCAR_BIT_ASYNC];
        nfast_ff  <= wr_data[`SCAR_BIT_NFAST];
        vector_ff <= wr_data[`SCAR_BIT_VECTOR];
        instruction_cache_ff <= wr_data[`SCAR_BIT_INSTRUCTION_CACHE];
        bigend_ff <= wr_data[`SCAR_BIT_BIGEND];
        data_cache_ff <= wr_data[`SCAR_BIT_DATA_CACHE];
        prot_ff   <= wr_data[`SCAR_BIT_PROT];
      end
      if (sel_dc) begin
        dcach_ff <= wr_data[7:0];
      end
      if (sel_ic) begin
        icach_ff <= wr_data[7:0];
      end
      if (sel_buf) begin
        buf_ff <= wr_data[7:0];
      end
    end
  end

  // Reserved bits read back as the should-be values so read-modify-write stays clean
  always @* begin
    nxt_rd_data = rd_data_ff;
    if (rd_ok) begin
      nxt_rd_data = 32'h00000000;
      if (sel_ctl) begin
        nxt_rd_data = `SCAR_RSVD_ONES;
        nxt_rd_data[`SCAR_BIT_ASYNC]  = async_ff;
        nxt_rd_data[`SCAR_BIT_NFAST]  = nfast_ff;
        nxt_rd_data[`SCAR_BIT_VECTOR] = vector_ff;
        nxt_rd_data[`SCAR_BIT_INSTRUCTION_CACHE] = instruction_cache_ff;
        nxt_rd_data[`SCAR_BIT_BIGEND] = bigend_ff;
        nxt_rd_data[`SCAR_BIT_DATA_CACHE] = data_cache_ff;
        nxt_rd_data[`SCAR_BIT_PROT]   = prot_ff;
      end else if (sel_dc) begin
        nxt_rd_data[7:0] = dcach_ff;
      end else if (sel_ic) begin
        nxt_rd_data[7:0] = icach_ff;
      end else if (sel_buf) begin
        nxt_rd_data[7:0] = buf_ff;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      rd_data_ff <= 32'h00000000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign vector_base          = vector_ff ? `SCAR_VEC_HIGH : `SCAR_VEC_LOW;
  assign instruction_cache_en = instruction_cache_ff;
  assign data_cache_en        = data_cache_ff;
  assign big_endian           = bigend_ff;
  assign protection_en        = prot_ff;
  assign async_clock_select   = async_ff;
  assign fast_bus_not_select  = nfast_ff;
  assign shared_clock_mode    = ({async_ff, nfast_ff} == `SCAR_MODE_FAST);
  assign sync_clock_mode      = ({async_ff, nfast_ff} == `SCAR_MODE_SYNC);
  assign async_clock_mode     = ({async_ff, nfast_ff} == `SCAR_MODE_ASYNC);
  // Flagged only; the clock logic decides what to do with it
  assign clock_mode_reserved  = ({async_ff, nfast_ff} == `SCAR_MODE_RSVD);
  assign data_cachable        = dcach_ff;
  assign instr_cachable       = icach_ff;
  assign area_bufferable_flag = buf_ff;

  scar_area_attr u_attr (
    .cachable    (dcach_ff),
    .bufferable  (buf_ff),
    .wr_buffered (data_wr_buffered),
    .wr_through  (data_wr_through)
  );
endmodule // scar_bank
`default_nettype wire

/* bench/scar_props.sv */
// Port assertions for the control and attribute bank
`default_nettype none
module scar_props (
  input wire logic        sys_clk, reset, vector_high_init_pin, cop_valid, core_to_coproc_write,
  input wire logic        coproc_to_core_read, other_coproc_instr, privileged, undef_trap, big_endian,
  input wire logic        instruction_cache_en, data_cache_en, protection_en, async_clock_mode, clock_mode_reserved,
  input wire logic [3:0]  coproc_reg_number,
  input wire logic [2:0]  opcode_2,
  input wire logic [31:0] wr_data, rd_data_ff, vector_base,
  input wire logic [7:0]  instr_cachable, data_cachable, area_bufferable_flag, data_wr_through
);
  timeunit 1ns;
  timeprecision 1ns;
  logic w1;
  assign w1 = cop_valid && privileged && core_to_coproc_write && coproc_reg_number == 4'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_vec; w1 |=> vector_base == ($past(wr_data[13]) ? 32'hffff0000 : 32'h0); endproperty
  a_vec: assert property (p_vec) else $error("vector base wrong");
  property p_bits; w1 |=> {instruction_cache_en, data_cache_en, protection_en} == $past({wr_data[12], wr_data[2], wr_data[0]}); endproperty
  a_bits: assert property (p_bits) else $error("enable bits wrong");
  property p_end; w1 |=> big_endian == $past(wr_data[7]); endproperty
  a_end: assert property (p_end) else $error("endian bit wrong");
  property p_mode; w1 |=> {async_clock_mode, clock_mode_reserved} == {&$past(wr_data[31:30]), $past(wr_data[31:30]) == 2'h2}; endproperty
  a_mode: assert property (p_mode) else $error("clock mode wrong");
  property p_rdsel; cop_valid && privileged && coproc_to_core_read && coproc_reg_number == 4'h2 && opcode_2 == 3'h1
    |=> rd_data_ff == {24'h0, $past(instr_cachable)}; endproperty
  a_rdsel: assert property (p_rdsel) else $error("cachable read wrong");
  property p_wthru; data_wr_through == (data_cachable & ~area_bufferable_flag); endproperty
  a_wthru: assert property (p_wthru) else $error("write through wrong");
  property p_trap; cop_valid && (other_coproc_instr || (!privileged && (core_to_coproc_write || coproc_to_core_read)))
    |-> undef_trap ##1 $stable(data_cachable); endproperty
  a_trap: assert property (p_trap) else $error("refused transfer wrong");
  property p_rst; $fell(reset) |-> vector_base == ($past(vector_high_init_pin) ? 32'hffff0000 : 32'h0)
    && !big_endian && {instr_cachable, data_cachable, area_bufferable_flag} == 24'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // scar_props
bind scar_bank scar_props chk_u (.*);
`default_nettype wire

/* bench/scar_core_model.sv */
// Core side model issuing coprocessor register transfers
`default_nettype none
module scar_core_model (
  input wire logic   sys_clk,
  output logic       cop_valid, core_to_coproc_write, coproc_to_core_read, other_coproc_instr, privileged,
  output logic [3:0] coproc_reg_number,
  output logic [2:0] opcode_2,
  output logic [31:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cop_valid, core_to_coproc_write, coproc_to_core_read, other_coproc_instr, privileged} = 5'h0;
  initial {coproc_reg_number, opcode_2, wr_data} = 39'h0;
  // One instruction per call; calls back to back give one per cycle
  task automatic xfer(input logic [4:0] k, input logic [3:0] rn, input logic [2:0] op2, input logic [31:0] d);
    @(negedge sys_clk);
    {cop_valid, core_to_coproc_write, coproc_to_core_read, other_coproc_instr, privileged} = k;
    {coproc_reg_number, opcode_2, wr_data} = {rn, op2, d};
    // Let the combinational trap settle before the caller looks
    #1;
  endtask
  // Idle core scrambles data so stale values never pass
  task automatic idle();
    @(negedge sys_clk);
    cop_valid = 1'b0;
    wr_data = ~wr_data;
  endtask
endmodule // scar_core_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the control and attribute bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, reset = 1'b1, vector_high_init_pin = 1'b1, undef_trap;
  logic        cop_valid, core_to_coproc_write, coproc_to_core_read, other_coproc_instr, privileged;
  logic        instruction_cache_en, data_cache_en, big_endian, protection_en, async_clock_select;
  logic        fast_bus_not_select, shared_clock_mode, sync_clock_mode, async_clock_mode, clock_mode_reserved;
  logic [3:0]  coproc_reg_number;
  logic [2:0]  opcode_2;
  logic [31:0] wr_data, rd_data_ff, vector_base, v, rs = 32'h5b;
  logic [7:0]  data_cachable, instr_cachable, area_bufferable_flag, data_wr_buffered, data_wr_through, dc, ic, bf;
  int          failures = 0, checked = 0;
  scar_core_model core_u (.*);
  scar_bank dut_u (.*);
  initial forever #25 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Control word with reserved bits at their required values
  function automatic logic [31:0] ctl(input logic [31:0] r, input logic [1:0] m);
    return {m, 16'h0, r[13:12], 4'h0, r[7], 4'hf, r[2], 1'b0, r[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    chk("vector", vector_base, 32'hffff0000);
    // Register four is never addressed by the stimulus
    for (int i = 0; i < 9; i++) begin
      rs = xs(rs);
      v = ctl(rs, (i % 3 == 2) ? 2'h3 : 2'(i % 3));
      core_u.xfer(5'h19, 4'h1, 3'h0, v);
      core_u.xfer(5'h15, 4'h1, 3'h0, 32'h0);
      chk("vec", vector_base, v[13] ? 32'hffff0000 : 32'h0);
      chk("bits", {instruction_cache_en, big_endian, data_cache_en, protection_en}, {v[12], v[7], v[2], v[0]});
      chk("mode", {async_clock_select, fast_bus_not_select, shared_clock_mode, sync_clock_mode, async_clock_mode},
          {v[31:30], v[31:30] == 2'h0, v[31:30] == 2'h1, v[31:30] == 2'h3});
      rs = xs(rs);
      {dc, ic, bf} = rs[23:0];
      core_u.xfer(5'h19, 4'h2, 3'h0, {24'h0, dc});
      chk("ctl rd", rd_data_ff & 32'hc0003085, v & 32'hc0003085);
      core_u.xfer(5'h19, 4'h2, 3'h1, {24'h0, ic});
      core_u.xfer(5'h19, 4'h3, 3'h0, {24'h0, bf});
      core_u.xfer(5'h18, 4'h2, 3'h0, ~{24'h0, dc});
      chk("trap", undef_trap, 1'b1);
      core_u.xfer(5'h13, 4'h2, 3'h0, 32'h0);
      chk("trap2", undef_trap, 1'b1);
      core_u.xfer(5'h15, 4'h2, 3'h0, 32'h0);
      core_u.xfer(5'h15, 4'h2, 3'h1, 32'h0);
      chk("dc rd", rd_data_ff, {24'h0, dc});
      core_u.xfer(5'h15, 4'h3, 3'h0, 32'h0);
      chk("ic rd", rd_data_ff, {24'h0, ic});
      core_u.idle();
      chk("bf rd", rd_data_ff, {24'h0, bf});
      chk("thru", data_wr_through, dc & ~bf);
      chk("wbuf", data_wr_buffered, bf);
      chk("attr", {instr_cachable, area_bufferable_flag}, {ic, bf});
      $display("test %0d done", i);
    end
    // Mid-run reset with the strap low
    vector_high_init_pin = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk("rst", {vector_base[31:16], big_endian, instr_cachable, data_cachable}, 32'h0);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
